// ---- common/cbit_consts.vh ----
// register offsets, field positions and timing counts for the id/stamp block
`ifndef CBIT_CONSTS_VH
`define CBIT_CONSTS_VH
// byte register indices; byte address is four times the index
`define CBIT_IDX_STAMP_HIGH 8'h2e
`define CBIT_IDX_STAMP_LOW 8'h2f
`define CBIT_IDX_ID_BYTE0 8'h30
`define CBIT_IDX_ID_BYTE1 8'h31
`define CBIT_IDX_ID_BYTE2 8'h32
`define CBIT_IDX_ID_BYTE3 8'h33
`define CBIT_IDX_CTRL 8'h40
`define CBIT_IDX_STATUS 8'h41
// identifier byte 1 field positions
`define CBIT_B1_MID_MSB 7
`define CBIT_B1_MID_LSB 5
`define CBIT_B1_SRR_BIT 4
`define CBIT_B1_IDE_BIT 3
`define CBIT_B1_LOW_MSB 2
`define CBIT_B1_LOW_LSB 0
// standard format: remote flag sits at bit 4 of byte 1
`define CBIT_B1_STD_RTR_BIT 4
// extended format: remote flag sits at bit 0 of byte 3
`define CBIT_B3_EXT_RTR_BIT 0
// control register bits
`define CBIT_CTRL_INIT_BIT 0
`define CBIT_CTRL_STAMP_EN_BIT 1
`define CBIT_CTRL_SEND_BIT 2
`define CBIT_CTRL_RESET 8'h01
// default bit time in nanoseconds (period 4 ns)
`define CBIT_BIT_TIME_NS 2000
`define CBIT_CLK_NS 4
`define CBIT_BIT_CYCLES (`CBIT_BIT_TIME_NS / `CBIT_CLK_NS)
`endif

// ---- src/cbit_id_stamp.v ----
// CAN message buffer identifier and receive time stamp block with an APB slave
// Notes on behaviour
// (RULE1) stamp timer into rx buffer after frame
// (RULE2) stamp timer counts internal bit clock
// (RULE3) timer wraps silently, no overrun flag
// (RULE4) timer cleared during initialization mode
// (RULE5) stamp bytes read-only, writes ignored
// (RULE6) software touches only empty selected buffer
// (RULE7) extended id 29 bits, 32 with flags
// (RULE8) identifier sent most significant bit first
// (RULE9) smallest identifier value wins arbitration
// (RULE10) standard id 11 bits, 13 with flags
// (RULE11) software sets substitute remote bit to one
// (RULE12) rx substitute remote stored as received
// (RULE13) extended flag picks 11 or 29 bits
// (RULE14) rx extended flag follows received format
// (RULE15) byte1 layout: mid, srr, ide, low
// (RULE16) standard byte0 shares extended byte0 offset
// (RULE17) remote flag picks data or remote frame
// (RULE18) high stamp register holds stamp bits 7..0
// (RULE19) 16-bit timer, one step per bit
// (RULE20) id and stamp bytes undefined after reset
`include "cbit_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module cbit_id_stamp #(
  parameter BIT_CYCLES = `CBIT_BIT_CYCLES,
  parameter STAMP_W = 16
) (
  input wire core_clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_frame_valid,
  input wire [28:0] rx_identifier,
  input wire rx_extended,
  input wire rx_substitute_remote,
  input wire rx_remote,
  input wire tx_buffer_empty_flag,
  input wire tx_buffer_select,
  input wire tx_arb_ready,
  input wire can_rx_pin,
  output reg can_tx_pin,
  output reg tx_arb_busy,
  output reg tx_arb_lost
);

  // synchronised pin copies; first stage read only by the second
  reg frame_meta_reg;
  reg frame_sync_reg;
  reg frame_prev_reg;
  reg rxpin_meta_reg;
  reg rxpin_sync_reg;
  reg empty_meta_reg;
  reg empty_sync_reg;
  reg sel_meta_reg;
  reg sel_sync_reg;
  reg arbrdy_meta_reg;
  reg arbrdy_sync_reg;

  // received frame fields, retimed like the strobe that qualifies them
  reg [28:0] rxid_meta_reg;
  reg [28:0] rxid_sync_reg;
  // flag order: extended, substitute remote, remote
  reg [2:0] rxflag_meta_reg;
  reg [2:0] rxflag_sync_reg;

  // control and timer state
  reg [7:0] ctrl_reg;
  reg [15:0] bitdiv_reg;
  reg [STAMP_W-1:0] timer_reg;
  reg bit_tick_reg;

  // buffer bytes carry no reset; contents undefined until written
  reg [STAMP_W-1:0] stamp_reg;
  reg [7:0] id_byte_reg [0:3];

  // transmit shifter
  reg [31:0] shift_reg;
  reg [5:0] shift_cnt_reg;
  // set once a header bit is on the bus, so the bus level can be judged
  reg bit_sent_reg;

  // read mux wire and decode
  reg [7:0] rd_byte;
  reg rd_hit;
  wire [9:0] word_idx;
  wire access_phase;
  wire wr_allowed;
  wire init_mode;
  wire frame_done;
  wire wr_commit;

  // word index is the byte-register index
  assign word_idx = paddr[11:2];
  assign access_phase = psel & penable;
  assign init_mode = ctrl_reg[`CBIT_CTRL_INIT_BIT];
  // (RULE6) guard writes to buffer
  assign wr_allowed = empty_sync_reg & sel_sync_reg;
  // rising edge of the synchronised frame-valid strobe marks end of frame
  assign frame_done = frame_sync_reg & ~frame_prev_reg;
  // writes land only at the edge that completes the access, with pready high;
  // landing earlier would apply the same write twice during the wait state
  assign wr_commit = access_phase & pready & pwrite;

  // decide whether an index maps to a register
  function is_mapped;
    input [9:0] idx;
    begin
      is_mapped = (idx >= {2'b00, `CBIT_IDX_STAMP_HIGH} && idx <= {2'b00, `CBIT_IDX_ID_BYTE3})
        || idx == {2'b00, `CBIT_IDX_CTRL} || idx == {2'b00, `CBIT_IDX_STATUS};
    end
  endfunction

  // two-flop synchronisers for every asynchronous input
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      frame_meta_reg <= 1'b0;
      frame_sync_reg <= 1'b0;
      frame_prev_reg <= 1'b0;
      rxpin_meta_reg <= 1'b1;
      rxpin_sync_reg <= 1'b1;
      empty_meta_reg <= 1'b0;
      empty_sync_reg <= 1'b0;
      sel_meta_reg <= 1'b0;
      sel_sync_reg <= 1'b0;
      arbrdy_meta_reg <= 1'b0;
      arbrdy_sync_reg <= 1'b0;
    end else begin
      frame_meta_reg <= rx_frame_valid;
      frame_sync_reg <= frame_meta_reg;
      frame_prev_reg <= frame_sync_reg;
      rxpin_meta_reg <= can_rx_pin;
      rxpin_sync_reg <= rxpin_meta_reg;
      empty_meta_reg <= tx_buffer_empty_flag;
      empty_sync_reg <= empty_meta_reg;
      sel_meta_reg <= tx_buffer_select;
      sel_sync_reg <= sel_meta_reg;
      arbrdy_meta_reg <= tx_arb_ready;
      arbrdy_sync_reg <= arbrdy_meta_reg;
    end
  end

  // field retiming; the fields settle two edges after they change, and the
  // strobe edge detect needs three, so the capture never reads a moving word
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxid_meta_reg <= 29'h00000000;
      rxid_sync_reg <= 29'h00000000;
      rxflag_meta_reg <= 3'h0;
      rxflag_sync_reg <= 3'h0;
    end else begin
      rxid_meta_reg <= rx_identifier;
      rxid_sync_reg <= rxid_meta_reg;
      rxflag_meta_reg <= {rx_extended, rx_substitute_remote, rx_remote};
      rxflag_sync_reg <= rxflag_meta_reg;
    end
  end

  // bit clock divider and free-running stamp timer
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bitdiv_reg <= 16'h0000;
      bit_tick_reg <= 1'b0;
      timer_reg <= {STAMP_W{1'b0}};
    end else if (init_mode) begin
      // (RULE4) clear in init
      bitdiv_reg <= 16'h0000;
      bit_tick_reg <= 1'b0;
      timer_reg <= {STAMP_W{1'b0}};
    end else begin
      // (RULE2) bit clock divider
      if (bitdiv_reg == BIT_CYCLES[15:0] - 16'h0001) begin
        bitdiv_reg <= 16'h0000;
        bit_tick_reg <= 1'b1;
      end else begin
        bitdiv_reg <= bitdiv_reg + 16'h0001;
        bit_tick_reg <= 1'b0;
      end
      // (RULE19) one step per bit
      // (RULE3) wrap silently, no flag
      if (bit_tick_reg)
        timer_reg <= timer_reg + {{(STAMP_W-1){1'b0}}, 1'b1};
    end
  end

  // capture the time stamp; no reset so the value is undefined until a frame
  always @(posedge core_clk) begin
    // (RULE1) stamp after valid frame
    if (frame_done && ctrl_reg[`CBIT_CTRL_STAMP_EN_BIT])
      stamp_reg <= timer_reg;
  end

  // identifier bytes: written by software or filled by reception
  // (RULE20) no reset on buffer bytes
  always @(posedge core_clk) begin
    // reception wins over a software write in the same cycle
    if (frame_done) begin
      // (RULE14) format as received
      if (rxflag_sync_reg[2]) begin
        id_byte_reg[0] <= rxid_sync_reg[28:21];
        // (RULE12) srr as received
        id_byte_reg[1] <= {rxid_sync_reg[20:18], rxflag_sync_reg[1], 1'b1,
          rxid_sync_reg[17:15]};
        id_byte_reg[2] <= rxid_sync_reg[14:7];
        id_byte_reg[3] <= {rxid_sync_reg[6:0], rxflag_sync_reg[0]};
      end else begin
        // (RULE10) 11-bit standard layout
        id_byte_reg[0] <= rxid_sync_reg[10:3];
        id_byte_reg[1] <= {rxid_sync_reg[2:0], rxflag_sync_reg[0], 1'b0, 3'b000};
      end
    end else if (wr_commit && wr_allowed) begin
      // (RULE16) shared offset byte 0
      if (word_idx == {2'b00, `CBIT_IDX_ID_BYTE0})
        id_byte_reg[0] <= pwdata[7:0];
      // (RULE15) byte1 field layout
      else if (word_idx == {2'b00, `CBIT_IDX_ID_BYTE1})
        id_byte_reg[1] <= pwdata[7:0];
      else if (word_idx == {2'b00, `CBIT_IDX_ID_BYTE2})
        id_byte_reg[2] <= pwdata[7:0];
      else if (word_idx == {2'b00, `CBIT_IDX_ID_BYTE3})
        id_byte_reg[3] <= pwdata[7:0];
    end
  end

  // control register; send bit self-clears once the shifter takes it
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `CBIT_CTRL_RESET;
    end else if (wr_commit && word_idx == {2'b00, `CBIT_IDX_CTRL}) begin
      // a software write wins over the self-clear of the send bit
      ctrl_reg <= pwdata[7:0];
    end else if (tx_arb_busy) begin
      ctrl_reg[`CBIT_CTRL_SEND_BIT] <= 1'b0;
    end
  end

  // read mux; stamp bytes are read-only
  always @* begin
    rd_byte = 8'h00;
    rd_hit = is_mapped(word_idx);
    // (RULE18) high register bits 7..0
    if (word_idx == {2'b00, `CBIT_IDX_STAMP_HIGH})
      rd_byte = stamp_reg[7:0];
    else if (word_idx == {2'b00, `CBIT_IDX_STAMP_LOW})
      rd_byte = stamp_reg[15:8];
    else if (word_idx == {2'b00, `CBIT_IDX_ID_BYTE0})
      rd_byte = id_byte_reg[0];
    else if (word_idx == {2'b00, `CBIT_IDX_ID_BYTE1})
      rd_byte = id_byte_reg[1];
    else if (word_idx == {2'b00, `CBIT_IDX_ID_BYTE2})
      rd_byte = id_byte_reg[2];
    else if (word_idx == {2'b00, `CBIT_IDX_ID_BYTE3})
      rd_byte = id_byte_reg[3];
    else if (word_idx == {2'b00, `CBIT_IDX_CTRL})
      rd_byte = ctrl_reg;
    else if (word_idx == {2'b00, `CBIT_IDX_STATUS})
      rd_byte = {4'h0, wr_allowed, tx_arb_lost, tx_arb_busy, init_mode};
  end

  // apb slave: one wait state, answer in the second access cycle
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (access_phase && !pready) begin
      pready <= 1'b1;
      prdata <= {24'h000000, rd_byte};
      // (RULE5) stamp writes ignored, flagged
      pslverr <= !rd_hit || (pwrite && (word_idx == {2'b00, `CBIT_IDX_STAMP_HIGH}
        || word_idx == {2'b00, `CBIT_IDX_STAMP_LOW}));
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // arbitration shifter: loads the frame header and sends it bit by bit
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= 32'h00000000;
      shift_cnt_reg <= 6'h00;
      can_tx_pin <= 1'b1;
      tx_arb_busy <= 1'b0;
      tx_arb_lost <= 1'b0;
      bit_sent_reg <= 1'b0;
    end else if (init_mode) begin
      shift_cnt_reg <= 6'h00;
      can_tx_pin <= 1'b1;
      tx_arb_busy <= 1'b0;
      bit_sent_reg <= 1'b0;
    end else if (!tx_arb_busy) begin
      can_tx_pin <= 1'b1;
      if (ctrl_reg[`CBIT_CTRL_SEND_BIT] && arbrdy_sync_reg) begin
        tx_arb_busy <= 1'b1;
        tx_arb_lost <= 1'b0;
        // fresh header: the idle level on the pin is not ours to judge
        bit_sent_reg <= 1'b0;
        // (RULE13) pick id format
        if (id_byte_reg[1][`CBIT_B1_IDE_BIT]) begin
          // (RULE7) 29 id bits, srr, ide, rtr
          // (RULE11) srr taken from software
          shift_reg <= {id_byte_reg[0], id_byte_reg[1][7:5], id_byte_reg[1][4],
            1'b1, id_byte_reg[1][2:0], id_byte_reg[2], id_byte_reg[3][7:1],
            id_byte_reg[3][`CBIT_B3_EXT_RTR_BIT]};
          shift_cnt_reg <= 6'd32;
        end else begin
          // (RULE17) remote flag sent as rtr
          shift_reg <= {id_byte_reg[0], id_byte_reg[1][7:5],
            id_byte_reg[1][`CBIT_B1_STD_RTR_BIT], 1'b0, 19'h00000};
          shift_cnt_reg <= 6'd13;
        end
      end
    end else if (bit_tick_reg) begin
      // the bus level judged here was driven one bit time ago; it has crossed the
      // synchroniser only because a bit lasts at least three clocks
      // (RULE9) recessive sent, dominant seen: a smaller identifier wins
      if (bit_sent_reg && can_tx_pin && !rxpin_sync_reg) begin
        tx_arb_lost <= 1'b1;
        tx_arb_busy <= 1'b0;
        can_tx_pin <= 1'b1;
      end else if (shift_cnt_reg == 6'h00) begin
        // last bit has had its full bit time; give the bus back
        tx_arb_busy <= 1'b0;
        can_tx_pin <= 1'b1;
      end else begin
        // (RULE8) msb first
        can_tx_pin <= shift_reg[31];
        shift_reg <= {shift_reg[30:0], 1'b0};
        shift_cnt_reg <= shift_cnt_reg - 6'h01;
        bit_sent_reg <= 1'b1;
      end
    end
  end

endmodule // cbit_id_stamp

`default_nettype wire

// ---- verif/cbit_id_stamp_checker.sv ----
// concurrent checks on the apb side and arbitration flags of the id/stamp block
`timescale 1ns/1ps
`default_nettype none
module cbit_id_stamp_checker #(
  parameter BIT_CYCLES = 4,
  parameter STAMP_W = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_arb_busy,
  input wire logic tx_arb_lost
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // stamp bytes sit at two fixed indices
  wire is_stamp = (paddr[11:2] == 10'h2e) || (paddr[11:2] == 10'h2f);
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_ready_time; (psel && !penable) ##1 (psel && penable) |=> pready; endproperty
  a_ready_time: assert property (p_ready_time) else $error("pready late");
  property p_err_with_ready; pslverr |-> pready; endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  property p_stamp_wr; pready && pwrite && is_stamp |-> pslverr; endproperty
  a_stamp_wr: assert property (p_stamp_wr) else $error("stamp write accepted");
  property p_err_read_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_read_zero: assert property (p_err_read_zero) else $error("refused read not zero");
  property p_upper_zero; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read lanes not zero");
  property p_rdata_hold; !pready |-> $stable(prdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("prdata moved without answer");
  property p_lost_clear; $rose(tx_arb_busy) |-> ##[0:1] !tx_arb_lost; endproperty
  a_lost_clear: assert property (p_lost_clear) else $error("lost flag kept at start");
endmodule // cbit_id_stamp_checker
bind cbit_id_stamp cbit_id_stamp_checker #(.BIT_CYCLES(BIT_CYCLES), .STAMP_W(STAMP_W)) chk_inst (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_arb_busy(tx_arb_busy), .tx_arb_lost(tx_arb_lost));
`default_nettype wire

// ---- verif/cbit_node_model.sv ----
// other bus nodes: wired-and bus level and an idle bus indication
`timescale 1ns/1ps
`default_nettype none
module cbit_node_model (
  input wire logic can_tx_pin,
  input wire logic force_dom,
  output logic can_rx_pin,
  output logic tx_arb_ready
);
  assign can_rx_pin = can_tx_pin & ~force_dom;
  // bus always idle between our frames, so sends start at once
  assign tx_arb_ready = 1'b1;
endmodule // cbit_node_model
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench: apb register access, frame capture, stamping, send
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((e) !== (s)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb;
  logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, rx_frame_valid = 0;
  logic rx_extended = 0, rx_substitute_remote = 0, rx_remote = 0, force_dom = 0;
  logic tx_buffer_empty_flag = 0, tx_buffer_select = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [28:0] rx_identifier = 0, id;
  wire [31:0] prdata;
  wire pready, pslverr, can_tx_pin, tx_arb_busy, tx_arb_lost, can_rx_pin, tx_arb_ready;
  integer errors = 0, checks_done = 0, cyc = 0, seed = 32'h29712c18, n, t0, tc, lo, k;
  logic [7:0] rd, b0, b1, b2, b3, sh, sl;
  logic txq[$];
  logic er, sr, rt;
  logic [15:0] st;
  cbit_id_stamp #(.BIT_CYCLES(4), .STAMP_W(16)) cbit_id_stamp_inst (.core_clk(core_clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_valid(rx_frame_valid), .rx_identifier(rx_identifier), .rx_extended(rx_extended),
    .rx_substitute_remote(rx_substitute_remote), .rx_remote(rx_remote),
    .tx_buffer_empty_flag(tx_buffer_empty_flag), .tx_buffer_select(tx_buffer_select),
    .tx_arb_ready(tx_arb_ready), .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin),
    .tx_arb_busy(tx_arb_busy), .tx_arb_lost(tx_arb_lost));
  cbit_node_model cbit_node_model_inst (.can_tx_pin(can_tx_pin), .force_dom(force_dom),
    .can_rx_pin(can_rx_pin), .tx_arb_ready(tx_arb_ready));
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // cycle count and hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      give_verdict;
    end
  end
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata[7:0]; er = pslverr; psel <= 0; penable <= 0;
  endtask
  // fields held steady around the valid pulse
  task frame(input logic x);
    @(posedge core_clk);
    rx_identifier <= id; rx_extended <= x; rx_substitute_remote <= sr; rx_remote <= rt;
    rx_frame_valid <= 1; tc = cyc + 3;
    repeat (6) @(posedge core_clk);
    rx_frame_valid <= 0;
    repeat (3) @(posedge core_clk);
  endtask
  task rd_stamp; apb(0, 10'h2e, 0); sh = rd; apb(0, 10'h2f, 0); sl = rd; endtask
  // bus level while a header is out, one sample per clock
  always @(posedge core_clk) if (tx_arb_busy === 1'b1) txq.push_back(can_tx_pin);
  // one header send; bits go msb first, each held one bit time of four clocks
  task send(input integer nb, input logic [31:0] hdr, input logic lose);
    txq.delete();
    apb(1, 10'h40, 8'h04);
    n = 0; while (tx_arb_busy !== 1'b1 && n < 200) begin @(posedge core_clk); n++; end
    `CHK("send start", 1'b1, tx_arb_busy)
    n = 0; while (tx_arb_busy !== 1'b0 && n < 2000) begin @(posedge core_clk); n++; end
    `CHK("send end", 1'b0, tx_arb_busy)
    `CHK("loss flag", lose, tx_arb_lost)
    if (!lose) begin
      `CHK("bit count", 1'b1, txq.size() >= 4 * nb)
      for (k = 0; k < nb; k++)
        `CHK("tx bit", hdr[31 - k], txq[txq.size() - 4 * nb + 4 * k])
    end
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1;
    apb(0, 10'h40, 0); `CHK("ctrl", 8'h01, rd)
    apb(1, 10'h40, 8'h03); id = $random(seed); sr = 1; rt = 0; frame(1); rd_stamp;
    `CHK("init stamp", 16'h0, {sl, sh})
    apb(1, 10'h2f, 8'h5a); `CHK("stamp wr err", 1'b1, er)
    apb(0, 10'h2f, 0); `CHK("stamp kept", 8'h00, rd)
    apb(0, 10'h3f0, 0); `CHK("unmapped err", 1'b1, er)
    apb(1, 10'h40, 8'h02); t0 = cyc;
    for (k = 0; k < 4; k++) begin
      id = $random(seed); sr = $random(seed); rt = $random(seed);
      repeat (20 + ($random(seed) & 63)) @(posedge core_clk);
      frame(k[0]); apb(0, 10'h30, 0); b0 = rd; apb(0, 10'h31, 0); b1 = rd; rd_stamp;
      if (k[0]) begin
        `CHK("ext b0", id[28:21], b0)
        `CHK("ext b1", {id[20:18], sr, 1'b1, id[17:15]}, b1)
      end else begin
        `CHK("std b0", id[10:3], b0)
        `CHK("std b1", {id[2:0], rt, 1'b0}, b1[7:3])
      end
      st = {sl, sh}; lo = (tc - t0) / 4 - 1;
      `CHK("stamp range", 1'b1, (st >= lo && st <= lo + 2))
    end
    apb(1, 10'h40, 8'h00); id = $random(seed); frame(0); rd_stamp;
    `CHK("stamp off", st, {sl, sh})
    tx_buffer_empty_flag <= 1; tx_buffer_select <= 1;
    repeat (4) @(posedge core_clk);
    // software keeps the substitute bit set
    b0 = $random(seed); b1 = ($random(seed) | 8'h10) & 8'hf7;
    apb(1, 10'h30, b0); apb(1, 10'h31, b1); apb(0, 10'h30, 0);
    `CHK("sw b0", b0, rd)
    apb(0, 10'h31, 0); `CHK("sw b1", b1, rd)
    // writes outside empty and selected are dropped
    tx_buffer_empty_flag <= 0;
    repeat (4) @(posedge core_clk);
    apb(1, 10'h30, ~b0); apb(0, 10'h30, 0); `CHK("locked b0", b0, rd)
    tx_buffer_empty_flag <= 1;
    repeat (4) @(posedge core_clk);
    // standard header: 11 id bits, remote flag, extension flag clear
    send(13, {b0, b1[7:3], 19'h0}, 0);
    // extended buffer keeps the substitute bit set
    b1 = b1 | 8'h18; b2 = $random(seed); b3 = $random(seed);
    apb(1, 10'h31, b1); apb(1, 10'h32, b2); apb(1, 10'h33, b3);
    // another node holds the bus dominant: the first recessive bit loses
    force_dom <= 1;
    send(32, {b0, b1, b2, b3}, 1);
    apb(0, 10'h41, 0); `CHK("status", 8'h0c, rd)
    force_dom <= 0;
    send(32, {b0, b1, b2, b3}, 0);
    `CHK("no loss", 1'b0, tx_arb_lost)
    give_verdict;
  end
endmodule // tb
`default_nettype wire
